// ### icf_interrupt_control.sv
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "icf_defines.svh"
module icf_interrupt_control
  import icf_pkg::*;
#(
  parameter int PORT_W = 8,
  parameter int ADDR_W = 3
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic timer_overflow,
  input wire logic external_irq_pin,
  input wire logic [PORT_W-1:0] port_b_pins,
  input wire logic periph_irq,
  output logic core_irq_req,
  output logic sys_irq
);
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  // the change mask lives in one byte and the map needs five offsets
  generate
    if (PORT_W < 1 || PORT_W > 8) begin : g_bad_port
      $error("port width must lie between 1 and 8");
    end
    if (ADDR_W < 3) begin : g_bad_addr
      $error("address width must be at least 3");
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin event detector
  // ----------------------------------------------------------------
  icf_evt_if #(.PORT_W(PORT_W)) evt ();

  icf_event_detect #(
    .PORT_W(PORT_W)
  ) u_detect (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .external_irq_pin(external_irq_pin),
    .port_b_pins(port_b_pins),
    .evt(evt)
  );

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  icf_byte_t ctrl_reg;
  icf_byte_t ctrl_next;
  icf_byte_t pcmask_reg;
  icf_byte_t edge_reg;
  icf_evt_t status_reg;
  icf_evt_t status_next;
  icf_evt_t mask_reg;
  icf_evt_t mask_next;
  icf_evt_t evt_vec;
  logic periph_prev_reg;
  icf_byte_t rdata_reg;
  logic core_req_reg;
  logic sys_irq_reg;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [2:0] addr_lo;
  logic addr_hi_zero;
  logic sel_ctrl;
  logic sel_pcmask;
  logic sel_edge;
  logic sel_status;
  logic sel_mask;
  logic wr_ctrl;
  logic wr_pcmask;
  logic wr_edge;
  logic wr_mask;
  logic rd_status;
  // upper address bits must be zero, otherwise the access is unmapped
  assign addr_lo = reg_addr[2:0];
  assign addr_hi_zero = (reg_addr >> 3) == '0;
  assign sel_ctrl = addr_hi_zero && (addr_lo == `ICF_OFS_CTRL);
  assign sel_pcmask = addr_hi_zero && (addr_lo == `ICF_OFS_PCMASK);
  assign sel_edge = addr_hi_zero && (addr_lo == `ICF_OFS_EDGE);
  assign sel_status = addr_hi_zero && (addr_lo == `ICF_OFS_STATUS);
  assign sel_mask = addr_hi_zero && (addr_lo == `ICF_OFS_MASK);
  assign wr_ctrl = reg_wr & sel_ctrl;
  assign wr_pcmask = reg_wr & sel_pcmask;
  assign wr_edge = reg_wr & sel_edge;
  assign wr_mask = reg_wr & sel_mask;
  assign rd_status = reg_rd & sel_status;

  // ----------------------------------------------------------------
  // interrupt_control next value
  // ----------------------------------------------------------------
  logic evt_tmr;
  logic evt_ext;
  logic evt_chg;
  icf_byte_t ctrl_src;
  assign evt_tmr = timer_overflow; // same-clock pulse from the timer
  assign evt_ext = evt.ext_evt;
  assign evt_chg = evt.chg_evt;
  // a write replaces the whole byte, flags included
  assign ctrl_src = wr_ctrl ? reg_wdata : ctrl_reg; // [RULE12]
  // enables follow software only
  assign ctrl_next[`ICF_BIT_GLOBAL_EN] =
    ctrl_src[`ICF_BIT_GLOBAL_EN]; // [RULE1]
  assign ctrl_next[`ICF_BIT_GROUP_EN] =
    ctrl_src[`ICF_BIT_GROUP_EN]; // [RULE2]
  assign ctrl_next[`ICF_BIT_TMR_EN] = ctrl_src[`ICF_BIT_TMR_EN]; // [RULE3]
  assign ctrl_next[`ICF_BIT_EXT_EN] = ctrl_src[`ICF_BIT_EXT_EN]; // [RULE4]
  assign ctrl_next[`ICF_BIT_CHG_EN] = ctrl_src[`ICF_BIT_CHG_EN]; // [RULE5]
  // flags: the event wins over a clearing write, enables not consulted
  assign ctrl_next[`ICF_BIT_TMR_FLAG] =
    evt_tmr | ctrl_src[`ICF_BIT_TMR_FLAG]; // [RULE6] [RULE10] [RULE12]
  assign ctrl_next[`ICF_BIT_EXT_FLAG] =
    evt_ext | ctrl_src[`ICF_BIT_EXT_FLAG]; // [RULE7] [RULE12]
  assign ctrl_next[`ICF_BIT_CHG_FLAG] =
    evt_chg | ctrl_src[`ICF_BIT_CHG_FLAG]; // [RULE8] [RULE12]

  // ----------------------------------------------------------------
  // core request
  // ----------------------------------------------------------------
  logic glb_en_next;
  logic pend_tmr;
  logic pend_ext;
  logic pend_chg;
  logic pend_per;
  logic flag_pend_next;
  logic core_req_next;
  assign glb_en_next = ctrl_next[`ICF_BIT_GLOBAL_EN];
  assign pend_tmr = ctrl_next[`ICF_BIT_TMR_EN] &
                    ctrl_next[`ICF_BIT_TMR_FLAG]; // [RULE3]
  assign pend_ext = ctrl_next[`ICF_BIT_EXT_EN] &
                    ctrl_next[`ICF_BIT_EXT_FLAG]; // [RULE4]
  assign pend_chg = ctrl_next[`ICF_BIT_CHG_EN] &
                    ctrl_next[`ICF_BIT_CHG_FLAG]; // [RULE5]
  // peripheral sources only pass with the group enable
  assign pend_per = ctrl_next[`ICF_BIT_GROUP_EN] & periph_irq; // [RULE2]
  assign flag_pend_next = pend_tmr | pend_ext | pend_chg;
  // global enable gates everything
  assign core_req_next = glb_en_next &
                         (flag_pend_next | pend_per); // [RULE1] [RULE11]

  // ----------------------------------------------------------------
  // sticky event status, cleared by reading it
  // ----------------------------------------------------------------
  logic periph_rise;
  logic sys_irq_next;
  assign periph_rise = periph_irq & ~periph_prev_reg;
  assign evt_vec[ICF_EV_TMR] = evt_tmr;
  assign evt_vec[ICF_EV_EXT] = evt_ext;
  assign evt_vec[ICF_EV_CHG] = evt_chg;
  assign evt_vec[ICF_EV_PER] = periph_rise;
  // a new event in the reading cycle survives the clear
  assign status_next = evt_vec | (rd_status ? 4'h0 : status_reg);
  assign mask_next = wr_mask ? reg_wdata[3:0] : mask_reg;
  assign sys_irq_next = |(status_next & mask_next);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  icf_byte_t rd_mux;
  assign rd_mux = sel_ctrl ? ctrl_reg :
                  sel_pcmask ? pcmask_reg :
                  sel_edge ? edge_reg :
                  sel_status ? {4'h0, status_reg} :
                  sel_mask ? {4'h0, mask_reg} :
                  8'h00;

  // ----------------------------------------------------------------
  // settings toward the detector
  // ----------------------------------------------------------------
  assign evt.ext_rising = edge_reg[`ICF_BIT_RISING];
  assign evt.pin_mask = pcmask_reg[PORT_W-1:0]; // [RULE9]

  // control byte and its request
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= `ICF_CTRL_RST;
      core_req_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      core_req_reg <= core_req_next; // [RULE11]
    end
  end

  // own configuration registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pcmask_reg <= `ICF_PCMASK_RST;
      edge_reg <= `ICF_EDGE_RST;
    end else begin
      pcmask_reg <= wr_pcmask ? reg_wdata : pcmask_reg;
      edge_reg <= wr_edge ? {7'h00, reg_wdata[`ICF_BIT_RISING]} : edge_reg;
    end
  end

  // status, mask and system interrupt line
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= 4'h0;
      mask_reg <= `ICF_MASK_RST;
      periph_prev_reg <= 1'b0;
      sys_irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      periph_prev_reg <= periph_irq;
      sys_irq_reg <= sys_irq_next;
    end
  end

  // read data stands for one cycle only
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;
  assign core_irq_req = core_req_reg;
  assign sys_irq = sys_irq_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // named pieces of the flag sequences
  sequence s_tmr_clear_write;
    wr_ctrl && !reg_wdata[`ICF_BIT_TMR_FLAG] && !timer_overflow;
  endsequence
  sequence s_ext_clear_write;
    wr_ctrl && !reg_wdata[`ICF_BIT_EXT_FLAG] && !evt.ext_evt;
  endsequence
  sequence s_chg_event;
    evt.chg_evt;
  endsequence
  sequence s_enabled_tmr;
    glb_en_next && ctrl_next[`ICF_BIT_TMR_EN] && timer_overflow;
  endsequence

  AST_GLOBAL_BLOCKS_ALL: assert property ( // [RULE1]
    !glb_en_next |=> !core_irq_req
  ) else $error("request raised with global enable low");

  AST_GROUP_GATES_PERIPH: assert property ( // [RULE2]
    (periph_irq && !ctrl_next[`ICF_BIT_GROUP_EN] && !flag_pend_next)
      |=> !core_irq_req
  ) else $error("peripheral request passed with group enable low");

  AST_TMR_EN_RAISES: assert property ( // [RULE3]
    s_enabled_tmr |=> core_irq_req ##0 ctrl_reg[`ICF_BIT_TMR_FLAG]
  ) else $error("enabled timer overflow did not request");

  AST_EXT_EN_RAISES: assert property ( // [RULE4]
    (glb_en_next && ctrl_next[`ICF_BIT_EXT_EN] && evt.ext_evt)
      |=> core_irq_req
  ) else $error("enabled pin event did not request");

  AST_CHG_EN_BLOCKS: assert property ( // [RULE5]
    (!ctrl_next[`ICF_BIT_CHG_EN] && ctrl_next[`ICF_BIT_CHG_FLAG] &&
     !pend_tmr && !pend_ext && !pend_per) |=> !core_irq_req
  ) else $error("change flag requested while disabled");

  AST_TMR_FLAG_STICKS: assert property ( // [RULE6]
    timer_overflow ##1 (!wr_ctrl)[*2] |=> ctrl_reg[`ICF_BIT_TMR_FLAG]
  ) else $error("timer flag lost without a write");

  AST_EXT_FLAG_CLEAR: assert property ( // [RULE7]
    s_ext_clear_write |=> !ctrl_reg[`ICF_BIT_EXT_FLAG]
  ) else $error("pin flag not cleared by software");

  AST_CHG_FLAG_SET: assert property ( // [RULE8]
    s_chg_event |=> ctrl_reg[`ICF_BIT_CHG_FLAG]
  ) else $error("change event did not set its flag");

  AST_TMR_FLAG_SET_WINS: assert property ( // [RULE10]
    (timer_overflow && wr_ctrl && !reg_wdata[`ICF_BIT_TMR_FLAG])
      |=> ctrl_reg[`ICF_BIT_TMR_FLAG]
  ) else $error("timer rollover lost to a clearing write");

  AST_REQ_FOLLOWS: assert property ( // [RULE11]
    core_irq_req |-> $past(glb_en_next) &&
      ($past(flag_pend_next) || $past(pend_per))
  ) else $error("request without an enabled cause");

  AST_TMR_CLEAR: assert property ( // [RULE12]
    s_tmr_clear_write |=> !ctrl_reg[`ICF_BIT_TMR_FLAG]
  ) else $error("timer flag not cleared by a zero write");

  // the read shows the value before the clear, then, with no event in the reading cycle, the status is empty
  AST_STATUS_READ_CLEAR: assert property (
    (rd_status && evt_vec == 4'h0) |=> status_reg == 4'h0 &&
      reg_rdata == $past({4'h0, status_reg})
  ) else $error("status not cleared by its read");
endmodule
`default_nettype wire

// ### icf_defines.svh
// How it works
// (RULE1) Bit 7 is the global enable; while it is 0 no source reaches the core.
// (RULE2) Bit 6 lets the peripheral group through; at 0 it blocks all of them.
// (RULE3) Bit 5 enables the timer overflow interrupt.
// (RULE4) Bit 4 enables the external pin interrupt.
// (RULE5) Bit 3 enables the port-B change interrupt.
// (RULE6) Bit 2 is set by a timer overflow and holds until software clears it.
// (RULE7) Bit 1 is set by an external pin event and holds until cleared.
// (RULE8) Bit 0 is set when any port-B pin changes and holds until cleared.
// (RULE9) A pin only counts for the change flag if its per-pin enable is set.
// (RULE10) The timer flag is set on rollover; software sets the timer first.
// (RULE11) The core request is high when global enable and an enabled flag meet.
// (RULE12) Flags are set regardless of enables; writing 0 clears, an event wins.
`ifndef ICF_DEFINES_SVH
`define ICF_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ICF_OFS_CTRL 3'h0
`define ICF_OFS_PCMASK 3'h1
`define ICF_OFS_EDGE 3'h2
`define ICF_OFS_STATUS 3'h3
`define ICF_OFS_MASK 3'h4

// ----------------------------------------------------------------
// field positions of interrupt_control
// ----------------------------------------------------------------
`define ICF_BIT_GLOBAL_EN 7
`define ICF_BIT_GROUP_EN 6
`define ICF_BIT_TMR_EN 5
`define ICF_BIT_EXT_EN 4
`define ICF_BIT_CHG_EN 3
`define ICF_BIT_TMR_FLAG 2
`define ICF_BIT_EXT_FLAG 1
`define ICF_BIT_CHG_FLAG 0
`define ICF_BIT_RISING 0

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define ICF_CTRL_RST 8'h00
`define ICF_PCMASK_RST 8'h00
`define ICF_EDGE_RST 8'h01
`define ICF_MASK_RST 4'h0
`define ICF_PRIME_CYCLES 2'h3

`endif

// ### icf_pkg.sv
package icf_pkg;
  // one register byte
  typedef logic [7:0] icf_byte_t;
  // one bit per event source in the sticky status
  typedef logic [3:0] icf_evt_t;
  // index of each source inside icf_evt_t
  typedef enum logic [1:0] {
    ICF_EV_TMR = 2'h0,
    ICF_EV_EXT = 2'h1,
    ICF_EV_CHG = 2'h2,
    ICF_EV_PER = 2'h3
  } icf_event_e;
endpackage

// ### icf_evt_if.sv
`timescale 1ns/100ps
`default_nettype none
// events from the pin detector and its settings from the registers
interface icf_evt_if #(
  parameter int PORT_W = 8
);
  logic ext_rising;
  logic [PORT_W-1:0] pin_mask;
  logic ext_evt;
  logic chg_evt;
  modport detector (input ext_rising, input pin_mask,
                    output ext_evt, output chg_evt);
  modport control (output ext_rising, output pin_mask,
                   input ext_evt, input chg_evt);
endinterface
`default_nettype wire

// ### icf_event_detect.sv
`timescale 1ns/100ps
`default_nettype none
`include "icf_defines.svh"
module icf_event_detect
  import icf_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic external_irq_pin,
  input wire logic [PORT_W-1:0] port_b_pins,
  icf_evt_if.detector evt
);
  // ----------------------------------------------------------------
  // synchronisers, one per pin
  // ----------------------------------------------------------------
  logic [PORT_W:0] pins_raw;
  logic [PORT_W:0] meta_reg;
  logic [PORT_W:0] stable_reg;
  logic [PORT_W:0] prev_reg;
  assign pins_raw = {port_b_pins, external_irq_pin};

  genvar gi;
  generate
    for (gi = 0; gi <= PORT_W; gi++) begin : g_sync
      // meta feeds only the stable stage; prev keeps the last level
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_reg[gi] <= 1'b0;
          stable_reg[gi] <= 1'b0;
          prev_reg[gi] <= 1'b0;
        end else begin
          meta_reg[gi] <= pins_raw[gi];
          stable_reg[gi] <= meta_reg[gi];
          prev_reg[gi] <= stable_reg[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // edge and change detection
  // ----------------------------------------------------------------
  logic [1:0] prime_reg;
  logic primed;
  logic ext_hit;
  logic chg_hit;
  // edges during the first cycles after reset are flushed pipeline values
  assign primed = (prime_reg == `ICF_PRIME_CYCLES);
  assign ext_hit = primed & (evt.ext_rising ?
                   (stable_reg[0] & ~prev_reg[0]) :
                   (~stable_reg[0] & prev_reg[0]));
  // only pins with their change enable set count [RULE9]
  assign chg_hit = primed &
    (|((stable_reg[PORT_W:1] ^ prev_reg[PORT_W:1]) & evt.pin_mask));

  // one-cycle event pulses toward the register block
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prime_reg <= 2'h0;
      evt.ext_evt <= 1'b0;
      evt.chg_evt <= 1'b0;
    end else begin
      prime_reg <= primed ? prime_reg : prime_reg + 2'h1;
      evt.ext_evt <= ext_hit;
      evt.chg_evt <= chg_hit; // [RULE8]
    end
  end
endmodule
`default_nettype wire

// ### icf_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// processor core stand-in
// ----------------------------------------------------------------
module icf_core_model
  import icf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic core_irq_req,
  output icf_byte_t irq_count
);
  logic req_reg;
  // count request rises as the core would take them
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_reg <= 1'b0;
      irq_count <= 8'h00;
    end else begin
      req_reg <= core_irq_req;
      if (core_irq_req && !req_reg) begin
        irq_count <= irq_count + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### interrupt_control_flags_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "icf_defines.svh"
module interrupt_control_flags_tb
  import icf_pkg::*;
;
  logic sys_clk;
  logic rst_b;
  logic [2:0] reg_addr;
  icf_byte_t reg_wdata;
  logic reg_wr;
  logic reg_rd;
  icf_byte_t reg_rdata;
  logic timer_overflow;
  logic external_irq_pin;
  logic [7:0] port_b_pins;
  logic periph_irq;
  logic core_irq_req;
  logic sys_irq;
  icf_byte_t irq_count;
  icf_byte_t rd_val;
  int err_count;
  int checks;

  // ----------------------------------------------------------------
  // clock, design and core model
  // ----------------------------------------------------------------
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  icf_interrupt_control #(.PORT_W(8), .ADDR_W(3)) dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timer_overflow(timer_overflow),
    .external_irq_pin(external_irq_pin), .port_b_pins(port_b_pins),
    .periph_irq(periph_irq), .core_irq_req(core_irq_req),
    .sys_irq(sys_irq)
  );

  icf_core_model core_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .core_irq_req(core_irq_req),
    .irq_count(irq_count)
  );

  // ----------------------------------------------------------------
  // report and compare
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check_byte(input icf_byte_t got, input icf_byte_t exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // register bus cycles
  // ----------------------------------------------------------------
  // write, optionally with a timer event in the same cycle
  task automatic reg_write(input logic [2:0] a, input icf_byte_t d,
                           input logic tov);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    timer_overflow <= tov;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    timer_overflow <= 1'b0;
    #1;
  endtask

  task automatic reg_read(input logic [2:0] a, output icf_byte_t d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic read_check(input logic [2:0] a, input icf_byte_t exp);
    icf_byte_t v;
    reg_read(a, v);
    check_byte(v, exp);
  endtask

  task automatic pulse_timer;
    @(posedge sys_clk);
    timer_overflow <= 1'b1;
    @(posedge sys_clk);
    timer_overflow <= 1'b0;
    #1;
  endtask

  // bounded wait for the core request to rise
  task automatic wait_irq;
    int n;
    n = 0;
    while (core_irq_req !== 1'b1 && n < 10) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check_bit(core_irq_req, 1'b1);
    // a request that never came ends the run
    if (core_irq_req !== 1'b1) begin
      finish_test();
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    timer_overflow = 1'b0;
    external_irq_pin = 1'b0;
    port_b_pins = 8'h00;
    periph_irq = 1'b0;
    err_count = 0;
    checks = 0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    // reset values and unmapped places
    check_bit(core_irq_req, 1'b0);
    read_check(`ICF_OFS_CTRL, `ICF_CTRL_RST);
    read_check(`ICF_OFS_PCMASK, `ICF_PCMASK_RST);
    read_check(`ICF_OFS_EDGE, `ICF_EDGE_RST);
    read_check(`ICF_OFS_MASK, {4'h0, `ICF_MASK_RST});
    reg_write(3'h5, 8'hff, 1'b0);
    read_check(3'h5, 8'h00);
    read_check(`ICF_OFS_CTRL, 8'h00);
    // timer flag and its enables
    pulse_timer();
    check_bit(core_irq_req, 1'b0);
    read_check(`ICF_OFS_CTRL, 8'h04);
    reg_write(`ICF_OFS_CTRL, 8'h24, 1'b0);
    check_bit(core_irq_req, 1'b0);
    reg_write(`ICF_OFS_CTRL, 8'ha4, 1'b0);
    check_bit(core_irq_req, 1'b1);
    reg_write(`ICF_OFS_CTRL, 8'h84, 1'b0);
    check_bit(core_irq_req, 1'b0);
    reg_write(`ICF_OFS_CTRL, 8'ha0, 1'b0);
    check_bit(core_irq_req, 1'b0);
    read_check(`ICF_OFS_CTRL, 8'ha0);
    // clear in the same cycle as an event keeps the flag
    reg_write(`ICF_OFS_CTRL, 8'ha0, 1'b1);
    check_bit(core_irq_req, 1'b1);
    read_check(`ICF_OFS_CTRL, 8'ha4);
    reg_write(`ICF_OFS_CTRL, 8'h90, 1'b0);
    // external pin rising edge
    @(posedge sys_clk);
    external_irq_pin <= 1'b1;
    wait_irq();
    repeat (5) @(posedge sys_clk);
    #1;
    check_bit(core_irq_req, 1'b1);
    read_check(`ICF_OFS_CTRL, 8'h92);
    reg_write(`ICF_OFS_CTRL, 8'h82, 1'b0);
    check_bit(core_irq_req, 1'b0);
    reg_write(`ICF_OFS_CTRL, 8'h00, 1'b0);
    // falling edge ignored with rising selected
    @(posedge sys_clk);
    external_irq_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    read_check(`ICF_OFS_CTRL, 8'h00);
    // falling edge selected: a rise is ignored, the fall sets the flag
    reg_write(`ICF_OFS_EDGE, 8'h00, 1'b0);
    read_check(`ICF_OFS_EDGE, 8'h00);
    reg_write(`ICF_OFS_CTRL, 8'h90, 1'b0);
    @(posedge sys_clk);
    external_irq_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    read_check(`ICF_OFS_CTRL, 8'h90);
    @(posedge sys_clk);
    external_irq_pin <= 1'b0;
    wait_irq();
    read_check(`ICF_OFS_CTRL, 8'h92);
    reg_write(`ICF_OFS_CTRL, 8'h00, 1'b0);
    // port change, masked then enabled
    reg_write(`ICF_OFS_CTRL, 8'h88, 1'b0);
    @(posedge sys_clk);
    port_b_pins <= 8'h02;
    repeat (6) @(posedge sys_clk);
    read_check(`ICF_OFS_CTRL, 8'h88);
    reg_write(`ICF_OFS_PCMASK, 8'h01, 1'b0);
    @(posedge sys_clk);
    port_b_pins <= 8'h03;
    wait_irq();
    read_check(`ICF_OFS_CTRL, 8'h89);
    reg_write(`ICF_OFS_CTRL, 8'h81, 1'b0);
    check_bit(core_irq_req, 1'b0);
    reg_write(`ICF_OFS_CTRL, 8'h00, 1'b0);
    // peripheral group gating
    @(posedge sys_clk);
    periph_irq <= 1'b1;
    reg_write(`ICF_OFS_CTRL, 8'h80, 1'b0);
    check_bit(core_irq_req, 1'b0);
    reg_write(`ICF_OFS_CTRL, 8'hc0, 1'b0);
    check_bit(core_irq_req, 1'b1);
    reg_write(`ICF_OFS_CTRL, 8'h40, 1'b0);
    check_bit(core_irq_req, 1'b0);
    @(posedge sys_clk);
    periph_irq <= 1'b0;
    reg_write(`ICF_OFS_CTRL, 8'h00, 1'b0);
    // sticky status, mask and system interrupt
    reg_read(`ICF_OFS_STATUS, rd_val);
    reg_write(`ICF_OFS_MASK, 8'h01, 1'b0);
    check_bit(sys_irq, 1'b0);
    pulse_timer();
    check_bit(sys_irq, 1'b1);
    read_check(`ICF_OFS_STATUS, 8'h01);
    @(posedge sys_clk);
    #1;
    check_bit(sys_irq, 1'b0);
    reg_write(`ICF_OFS_MASK, 8'h00, 1'b0);
    pulse_timer();
    check_bit(sys_irq, 1'b0);
    read_check(`ICF_OFS_STATUS, 8'h01);
    // the core saw one request rise per enabled scenario
    check_byte(irq_count, 8'h06);
    finish_test();
  end
endmodule
`default_nettype wire
